// File: src/ucs_pkg.sv
// package for the undercurrent stage: constants, types and layouts
package ucs_pkg;

	// timing base and program cycle
	localparam int unsigned CLK_PERIOD_NS   = 50;
	localparam int unsigned TIME_BASE_MS    = 5;
	localparam int unsigned TICK_CYCLES     =
		(TIME_BASE_MS * 1000000) / CLK_PERIOD_NS;
	localparam int unsigned BLOCK_LEAD_MS   = 5;
	localparam int unsigned OP_DELAY_MAX_MS = 1800000;
	localparam int unsigned PRE_TRIG_MS     = 20;
	localparam int unsigned PREFAULT_MS     = 200;
	localparam int unsigned PRE_TRIG_TICKS  = PRE_TRIG_MS / TIME_BASE_MS;
	localparam int unsigned PREFAULT_TICKS  = PREFAULT_MS / TIME_BASE_MS;

	// hysteresis: reset at 103 percent of threshold
	localparam int unsigned HYST_NUM = 103;
	localparam int unsigned HYST_DEN = 100;

	// record store
	localparam int unsigned REC_DEPTH = 12;

	// widths
	localparam int unsigned CUR_W  = 16;
	localparam int unsigned TIME_W = 21;
	localparam int unsigned CNT_W  = 16;
	localparam int unsigned TS_W   = 48;

	// register offsets (word index on the plain port)
	localparam logic [7:0] REG_CTRL      = 8'h00;
	localparam logic [7:0] REG_THRESH    = 8'h01;
	localparam logic [7:0] REG_NOLOAD    = 8'h02;
	localparam logic [7:0] REG_DELAY     = 8'h03;
	localparam logic [7:0] REG_EVMASK    = 8'h04;
	localparam logic [7:0] REG_STATUS    = 8'h05;
	localparam logic [7:0] REG_EXPTIME   = 8'h06;
	localparam logic [7:0] REG_CNT_START = 8'h07;
	localparam logic [7:0] REG_CNT_TRIP  = 8'h08;
	localparam logic [7:0] REG_CNT_BLK   = 8'h09;
	localparam logic [7:0] REG_CNT_CLR   = 8'h0A;
	localparam logic [7:0] REG_REC_SEL   = 8'h0B;
	localparam logic [7:0] REG_REC_BASE  = 8'h10;
	localparam logic [7:0] REG_REC_LAST  = 8'h17;

	// control fields
	localparam int unsigned CTRL_FORCE_EN = 0;
	localparam int unsigned CTRL_FORCE_LO = 1;
	localparam int unsigned CTRL_GROUP_LO = 4;

	// reset values
	localparam logic [CUR_W-1:0]  THRESH_RST  = 16'h0200;
	localparam logic [CUR_W-1:0]  NOLOAD_RST  = 16'h00CD;
	localparam logic [TIME_W-1:0] DELAY_RST   = 21'h003E8;
	localparam logic [5:0]        EVMASK_RST  = 6'h3F;

	typedef enum logic [1:0] {
		UCS_NORMAL,
		UCS_START,
		UCS_TRIP,
		UCS_BLOCKED
	} ucs_cond_t;

	// event identifiers, ON/OFF per start, trip, blocked
	typedef enum logic [2:0] {
		UCS_EV_START_ON,
		UCS_EV_START_OFF,
		UCS_EV_TRIP_ON,
		UCS_EV_TRIP_OFF,
		UCS_EV_BLK_ON,
		UCS_EV_BLK_OFF
	} ucs_ev_t;

	typedef struct packed {
		logic [CUR_W-1:0] l1;
		logic [CUR_W-1:0] l2;
		logic [CUR_W-1:0] l3;
	} ucs_phase_t;

	typedef struct packed {
		logic            valid;
		ucs_ev_t         code;
		logic [TS_W-1:0] stamp;
	} ucs_event_t;

	typedef struct packed {
		logic [TS_W-1:0]   stamp;
		ucs_ev_t           code;
		logic [2:0]        phases;
		logic [CUR_W-1:0]  pre_trig;
		logic [CUR_W-1:0]  fault;
		logic [CUR_W-1:0]  prefault;
		logic [TIME_W-1:0] remain_ms;
		logic [2:0]        group;
	} ucs_record_t;

endpackage

// File: src/ucs_stage.sv
// undercurrent stage: timing, blocking, events, counters and records
// Operation
// - fixed operate delay only, no inverse curve
// - condition shows normal, start, trip, blocked
// - report expected operating time up to 1800 s
// - sample blocking once per program cycle
// - unblocked pick-up raises start, starts timing
// - blocked pick-up raises blocked, no timing
// - blocking during start drops start, release
// - six ON/OFF events for start, trip, blocked
// - per-event ON/OFF selection for buffer
// - every event carries a time stamp
// - clearable counters for start, trip, blocked
// - twelve records, oldest overwritten when full
// - record written only on ON transitions
// - record holds stamp, event, phases, currents
// - reset only above 103 percent of threshold or when locked
// - locked while current below no-load level
// - three fundamental magnitudes on 5 ms base
// - forcing overrides condition to chosen value
`timescale 1ns/1ns
module ucs_stage #(
	parameter int unsigned TICK_CYC = ucs_pkg::TICK_CYCLES
) (
	input  wire logic                         clk_in,
	input  wire logic                         reset_n_in,
	input  wire logic                         clk_en_in,
	input  wire ucs_pkg::ucs_phase_t          meas_in,
	input  wire logic                         block_in,
	input  wire logic [ucs_pkg::TS_W-1:0]     time_stamp_in,
	input  wire logic [7:0]                   addr_in,
	input  wire logic [31:0]                  wdata_in,
	input  wire logic                         wr_in,
	input  wire logic                         rd_in,
	output logic [31:0]                       rdata_out,
	output logic                              start_out,
	output logic                              trip_out,
	output logic                              blocked_out,
	output ucs_pkg::ucs_event_t               event_out
);
	import ucs_pkg::*;

	// program cycle tick every 5 ms
	logic [22:0] tick_cnt_r;
	wire         tick = (tick_cnt_r == 23'(TICK_CYC - 1));

	// settings
	logic [7:0]        ctrl_r;
	logic [CUR_W-1:0]  thresh_r;
	logic [CUR_W-1:0]  noload_r;
	logic [TIME_W-1:0] delay_r;
	logic [5:0]        evmask_r;
	logic [3:0]        rec_sel_r;

	// stage state
	logic              pick_r;
	logic              blk_s_r;
	logic              st_r;
	logic              tr_r;
	logic              bl_r;
	logic [TIME_W-1:0] elapsed_r;
	logic [CNT_W-1:0]  cnt_r [3];

	// current history for pre-trigger and prefault values
	logic [CUR_W-1:0]  hist_r [PREFAULT_TICKS];
	logic [CUR_W-1:0]  prefault_hold_r;

	// record store, circular
	ucs_record_t       rec_r [REC_DEPTH];
	logic [3:0]        wr_ptr_r;
	ucs_record_t       rec_nxt;

	// per-phase comparisons with hysteresis
	logic [2:0] below_set;
	logic [2:0] above_rst;
	logic [2:0] below_nl;
	logic [CUR_W-1:0] ph [3];
	assign ph[0] = meas_in.l1;
	assign ph[1] = meas_in.l2;
	assign ph[2] = meas_in.l3;
	wire [CUR_W+6:0] rst_lvl = (CUR_W+7)'(thresh_r * HYST_NUM / HYST_DEN);
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_ph
			assign below_set[gi] = ph[gi] < thresh_r;
			assign above_rst[gi] = (CUR_W+7)'(ph[gi]) >= rst_lvl;
			assign below_nl[gi]  = ph[gi] < noload_r;
		end
	endgenerate

	wire locked    = |below_nl;
	wire pick_set  = |below_set && !locked;
	wire pick_drop = (&above_rst) || locked;
	wire pick_nxt  = pick_r ? !pick_drop : pick_set;

	// fixed delay timing; blocking stops start and trip
	wire timing    = pick_nxt && !blk_s_r;
	wire expired   = elapsed_r + TIME_W'(TIME_BASE_MS) >= delay_r;
	wire st_nxt    = timing;
	wire tr_nxt    = timing && (tr_r || (st_r && expired));
	wire bl_nxt    = pick_nxt && blk_s_r && !st_r && !tr_r ? 1'b1 :
		pick_nxt && blk_s_r && bl_r;

	// forced status overrides measurements
	wire       force_en = ctrl_r[CTRL_FORCE_EN];
	ucs_cond_t force_val;
	assign force_val = ucs_cond_t'(ctrl_r[CTRL_FORCE_LO +: 2]);
	ucs_cond_t cond;
	assign cond = force_en ? force_val :
		tr_r ? UCS_TRIP : st_r ? UCS_START :
		bl_r ? UCS_BLOCKED : UCS_NORMAL;
	assign start_out   = cond == UCS_START;
	assign trip_out    = cond == UCS_TRIP;
	assign blocked_out = cond == UCS_BLOCKED;

	// expected operating time, saturated at 1800 s
	wire [TIME_W-1:0] remain = (st_r && !tr_r && delay_r > elapsed_r) ?
		delay_r - elapsed_r : '0;

	// edges of the visible outputs; six events
	logic [2:0] prev_r;
	wire  [2:0] now  = {blocked_out, trip_out, start_out};
	wire  [2:0] rise = now & ~prev_r;
	wire  [2:0] fall = ~now & prev_r;
	wire  [5:0] ev_all = {fall[2], rise[2], fall[1], rise[1],
		fall[0], rise[0]};
	wire  [5:0] ev_sel = ev_all & evmask_r;

	// lowest event goes out; a second one in the same cycle waits
	// one cycle in pend_r, so start OFF never hides trip ON
	logic [5:0]      pend_r;
	logic [TS_W-1:0] pend_stamp_r;
	wire  [5:0]      ev_req = ev_sel | pend_r;
	logic [2:0]      ev_idx;
	always_comb begin
		ev_idx = 3'h0;
		for (int i = 5; i >= 0; i--) begin
			if (ev_req[i]) begin
				ev_idx = 3'(i);
			end
		end
	end
	wire  [5:0]      ev_grant = 6'h01 << ev_idx;
	wire             ev_late  = |(pend_r & ev_grant);

	// record content for the newest ON transition
	logic [2:0] on_idx;
	always_comb begin
		on_idx = 3'h0;
		for (int i = 2; i >= 0; i--) begin
			if (rise[i]) begin
				on_idx = 3'(i);
			end
		end
	end
	wire [CUR_W-1:0] min_cur = (ph[0] < ph[1]) ?
		((ph[0] < ph[2]) ? ph[0] : ph[2]) :
		((ph[1] < ph[2]) ? ph[1] : ph[2]);
	always_comb begin
		rec_nxt           = '0;
		rec_nxt.stamp     = time_stamp_in;
		rec_nxt.code      = ucs_ev_t'({on_idx[1:0], 1'b0});
		rec_nxt.phases    = below_set;
		rec_nxt.pre_trig  = hist_r[PRE_TRIG_TICKS-1];
		rec_nxt.fault     = min_cur;
		rec_nxt.prefault  = start_out ? hist_r[PREFAULT_TICKS-1] :
			prefault_hold_r;
		rec_nxt.remain_ms = remain;
		rec_nxt.group     = ctrl_r[CTRL_GROUP_LO +: 3];
	end

	// register decode
	wire        rec_hit  = addr_in >= REG_REC_BASE && addr_in <= REG_REC_LAST;
	wire [2:0]  rec_word = addr_in[2:0];
	wire [255:0] rec_flat = 256'(rec_r[rec_sel_r]);
	wire        clr_req  = clk_en_in && wr_in && addr_in == REG_CNT_CLR;
	logic [31:0] rd_mux;
	always_comb begin
		if (addr_in == REG_CTRL) begin
			rd_mux = 32'(ctrl_r);
		end else if (addr_in == REG_THRESH) begin
			rd_mux = 32'(thresh_r);
		end else if (addr_in == REG_NOLOAD) begin
			rd_mux = 32'(noload_r);
		end else if (addr_in == REG_DELAY) begin
			rd_mux = 32'(delay_r);
		end else if (addr_in == REG_EVMASK) begin
			rd_mux = 32'(evmask_r);
		end else if (addr_in == REG_STATUS) begin
			rd_mux = 32'({pick_r, locked, cond});
		end else if (addr_in == REG_EXPTIME) begin
			rd_mux = 32'(remain);
		end else if (addr_in == REG_CNT_START) begin
			rd_mux = 32'(cnt_r[0]);
		end else if (addr_in == REG_CNT_TRIP) begin
			rd_mux = 32'(cnt_r[1]);
		end else if (addr_in == REG_CNT_BLK) begin
			rd_mux = 32'(cnt_r[2]);
		end else if (addr_in == REG_REC_SEL) begin
			rd_mux = 32'(rec_sel_r);
		end else if (rec_hit) begin
			rd_mux = rec_flat[rec_word*32 +: 32];
		end else begin
			rd_mux = 32'h0000_0000;
		end
	end

	// program cycle divider
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			tick_cnt_r <= '0;
		end else if (clk_en_in) begin
			tick_cnt_r <= tick ? '0 : tick_cnt_r + 23'h1;
		end
	end

	// settings written over the plain port
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			ctrl_r    <= '0;
			thresh_r  <= THRESH_RST;
			noload_r  <= NOLOAD_RST;
			delay_r   <= DELAY_RST;
			evmask_r  <= EVMASK_RST;
			rec_sel_r <= '0;
			rdata_out <= '0;
		end else if (clk_en_in) begin
			rdata_out <= rd_in ? rd_mux : 32'h0000_0000;
			if (wr_in && addr_in == REG_CTRL) begin
				ctrl_r <= wdata_in[7:0];
			end
			if (wr_in && addr_in == REG_THRESH) begin
				thresh_r <= wdata_in[CUR_W-1:0];
			end
			if (wr_in && addr_in == REG_NOLOAD) begin
				noload_r <= wdata_in[CUR_W-1:0];
			end
			if (wr_in && addr_in == REG_DELAY) begin
				// clamp to 1800 s, the longest fixed delay
				delay_r <= (wdata_in > 32'(OP_DELAY_MAX_MS)) ?
					TIME_W'(OP_DELAY_MAX_MS) : wdata_in[TIME_W-1:0];
			end
			if (wr_in && addr_in == REG_EVMASK) begin
				evmask_r <= wdata_in[5:0];
			end
			if (wr_in && addr_in == REG_REC_SEL) begin
				rec_sel_r <= (wdata_in[3:0] < 4'(REC_DEPTH)) ?
					wdata_in[3:0] : 4'h0;
			end
		end
	end

	// stage state, evaluated once per program cycle
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			pick_r    <= 1'b0;
			blk_s_r   <= 1'b0;
			st_r      <= 1'b0;
			tr_r      <= 1'b0;
			bl_r      <= 1'b0;
			elapsed_r <= '0;
		end else if (clk_en_in && tick) begin
			blk_s_r   <= block_in;
			pick_r    <= pick_nxt;
			st_r      <= st_nxt;
			tr_r      <= tr_nxt;
			bl_r      <= bl_nxt;
			// release clears elapsed time at once
			elapsed_r <= (timing && !expired) ?
				elapsed_r + TIME_W'(TIME_BASE_MS) :
				timing ? elapsed_r : '0;
		end
	end

	// current history, one sample per 5 ms
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			for (int i = 0; i < PREFAULT_TICKS; i++) begin
				hist_r[i] <= '0;
			end
			prefault_hold_r <= '0;
		end else if (clk_en_in) begin
			if (tick) begin
				hist_r[0] <= min_cur;
				for (int i = 1; i < PREFAULT_TICKS; i++) begin
					hist_r[i] <= hist_r[i-1];
				end
			end
			if (rise[0]) begin
				prefault_hold_r <= hist_r[PREFAULT_TICKS-1];
			end
		end
	end

	// events, counters and records
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			prev_r    <= '0;
			event_out <= '0;
			pend_r    <= '0;
			pend_stamp_r <= '0;
			wr_ptr_r  <= '0;
			for (int i = 0; i < 3; i++) begin
				cnt_r[i] <= '0;
			end
			for (int i = 0; i < REC_DEPTH; i++) begin
				rec_r[i] <= '0;
			end
		end else if (clk_en_in) begin
			prev_r          <= now;
			event_out.valid <= |ev_req;
			event_out.code  <= ucs_ev_t'(ev_idx);
			event_out.stamp <= ev_late ? pend_stamp_r : time_stamp_in;
			// a waiting event keeps the stamp of its own change
			pend_r          <= ev_req & ~ev_grant;
			if (|ev_sel) begin
				pend_stamp_r <= time_stamp_in;
			end
			// an occurrence in the clear cycle still counts
			for (int i = 0; i < 3; i++) begin
				if (rise[i]) begin
					cnt_r[i] <= (clr_req && wdata_in[i]) ?
						CNT_W'(1) : cnt_r[i] + 1'b1;
				end else if (clr_req && wdata_in[i]) begin
					cnt_r[i] <= '0;
				end
			end
			if (|rise) begin
				rec_r[wr_ptr_r] <= rec_nxt;
				wr_ptr_r <= (wr_ptr_r == 4'(REC_DEPTH - 1)) ?
					4'h0 : wr_ptr_r + 4'h1;
			end
		end
	end

	AST_TRIP_NEEDS_START: assert property (@(posedge clk_in)
		disable iff (!reset_n_in)
		$rose(tr_r) |-> $past(st_r))
		else $error("trip without prior start");
	AST_BLOCK_NO_START: assert property (@(posedge clk_in)
		disable iff (!reset_n_in)
		bl_r |-> !st_r && !tr_r)
		else $error("blocked while timing");
	AST_BLOCK_DROPS_START: assert property (@(posedge clk_in)
		disable iff (!reset_n_in)
		clk_en_in && tick && blk_s_r |=> !st_r)
		else $error("start held under blocking");
	AST_EXPTIME_RANGE: assert property (@(posedge clk_in)
		disable iff (!reset_n_in)
		remain <= TIME_W'(OP_DELAY_MAX_MS))
		else $error("expected time above limit");
	AST_LOCKED_NO_START: assert property (@(posedge clk_in)
		disable iff (!reset_n_in)
		clk_en_in && tick && locked |=> !st_r && !tr_r)
		else $error("start while locked");
	AST_EVENT_MASKED: assert property (@(posedge clk_in)
		disable iff (!reset_n_in)
		clk_en_in && |ev_all && !(|ev_sel) && !(|pend_r) |=>
		!event_out.valid)
		else $error("masked event emitted");
	AST_REC_PTR_WRAP: assert property (@(posedge clk_in)
		disable iff (!reset_n_in)
		wr_ptr_r < 4'(REC_DEPTH))
		else $error("record pointer out of range");
	AST_REC_ON_ONLY: assert property (@(posedge clk_in)
		disable iff (!reset_n_in)
		clk_en_in && !(|rise) |=> $stable(wr_ptr_r))
		else $error("record written without ON edge");
	AST_FORCE: assert property (@(posedge clk_in)
		disable iff (!reset_n_in)
		force_en |-> cond == force_val)
		else $error("forced status ignored");

endmodule

// File: bench/ucs_meas_model.sv
// far side model: phase magnitudes, blocking matrix, time stamp
`timescale 1ns/1ns
module ucs_meas_model (
	input  wire logic                     clk_in,
	input  wire logic [15:0]              level_in,
	input  wire logic                     blk_req_in,
	output ucs_pkg::ucs_phase_t           meas_out,
	output logic                          block_out,
	output logic [ucs_pkg::TS_W-1:0]      stamp_out
);
	import ucs_pkg::*;
	// stamp starts at one, so a zero stamp means none was taken
	logic [TS_W-1:0] stamp_r = 48'h000000000001;
	assign stamp_out = stamp_r;
	// l2 carries the fault, others stay healthy; all updated every clock
	always @(posedge clk_in) begin
		meas_out  <= '{16'h0300, level_in, 16'h0300};
		block_out <= blk_req_in; // level held well past 5 ms lead
		stamp_r   <= stamp_r + 48'h000000000001;
	end
endmodule

// File: bench/tb_undercurrent_block_and_records.sv
// self-checking bench for the undercurrent stage
`timescale 1ns/1ns
module tb_undercurrent_block_and_records;
	import ucs_pkg::*;
	logic        clk_in = 1'b0;
	logic        reset_n_in = 1'b0;
	logic [7:0]  addr_in = 8'h00;
	logic [31:0] wdata_in = 32'h0;
	logic        wr_in = 1'b0;
	logic        rd_in = 1'b0;
	logic [15:0] level = 16'h0300;
	logic        blk_req = 1'b0;
	logic [31:0] rdata_out;
	logic        start_out, trip_out, blocked_out;
	ucs_event_t  event_out;
	ucs_phase_t  meas;
	logic        block;
	logic [47:0] stamp;
	logic [5:0]  ev_seen = 6'h00;
	logic        ev_nostamp = 1'b0;
	int          n_mismatch = 0;
	int          compares = 0;
	logic [31:0] rv;

	always #25 clk_in = ~clk_in;

	ucs_meas_model model (.clk_in(clk_in), .level_in(level),
		.blk_req_in(blk_req), .meas_out(meas), .block_out(block),
		.stamp_out(stamp));

	// short tick keeps a 5 ms step at four clocks
	ucs_stage #(.TICK_CYC(4)) uut (.clk_in(clk_in),
		.reset_n_in(reset_n_in), .clk_en_in(1'b1), .meas_in(meas),
		.block_in(block), .time_stamp_in(stamp), .addr_in(addr_in),
		.wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
		.rdata_out(rdata_out), .start_out(start_out),
		.trip_out(trip_out), .blocked_out(blocked_out),
		.event_out(event_out));

	// collect event codes; a zero stamp would mean no capture
	always @(posedge clk_in) begin
		if (event_out.valid === 1'b1) begin
			ev_seen[event_out.code] <= 1'b1;
			if (event_out.stamp === 48'h0)
				ev_nostamp <= 1'b1;
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_in);
		addr_in  <= a;
		wdata_in <= d;
		wr_in    <= 1'b1;
		@(posedge clk_in);
		wr_in <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_in);
		addr_in <= a;
		rd_in   <= 1'b1;
		@(posedge clk_in);
		rd_in <= 1'b0;
		// read data stand only in the cycle after the strobe
		#1 d = rdata_out;
	endtask

	// bounded wait for {blocked,trip,start} under a mask
	task automatic wait_out(input logic [2:0] m, input logic [2:0] v);
		int i;
		for (i = 0; i < 60; i++) begin
			@(posedge clk_in);
			#1;
			if (({blocked_out, trip_out, start_out} & m) === v)
				break;
		end
		chk({29'h0, {blocked_out, trip_out, start_out} & m}, {29'h0, v});
	endtask

	task automatic hold(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask

	task automatic t_reset;
		chk({29'h0, blocked_out, trip_out, start_out}, 32'h0);
		rd(REG_THRESH, rv);  chk(rv, 32'h00000200);
		rd(REG_NOLOAD, rv);  chk(rv, 32'h000000CD);
		rd(REG_DELAY, rv);   chk(rv, 32'h000003E8);
		rd(REG_EVMASK, rv);  chk(rv, 32'h0000003F);
		rd(8'h0C, rv);       chk(rv, 32'h0);
		$display("test reset values done");
	endtask

	task automatic t_trip;
		wr(REG_DELAY, 32'h00000014);
		level <= 16'h0100;
		wait_out(3'b001, 3'b001);
		rd(REG_STATUS, rv);  chk({30'h0, rv[1:0]}, 32'h1);
		rd(REG_EXPTIME, rv); chk({31'h0, rv <= 32'h14}, 32'h1);
		wait_out(3'b010, 3'b010);
		// above threshold but below the 103 percent reset level
		level <= 16'h0208;
		hold(20);
		chk({31'h0, trip_out}, 32'h1);
		level <= 16'h0220;
		wait_out(3'b011, 3'b000);
		hold(8);
		chk({26'h0, ev_seen & 6'h0F}, 32'h0F);
		chk({31'h0, ev_nostamp}, 32'h0);
		rd(REG_CNT_START, rv); chk(rv, 32'h1);
		rd(REG_CNT_TRIP, rv);  chk(rv, 32'h1);
		wr(REG_REC_SEL, 32'h0);
		rd(REG_REC_BASE, rv);  chk({29'h0, rv[2:0]}, 32'h5);
		$display("test pick-up and trip done");
	endtask

	task automatic t_blocked;
		blk_req <= 1'b1;
		hold(12);
		level <= 16'h0100;
		wait_out(3'b100, 3'b100);
		hold(20);
		chk({29'h0, blocked_out, trip_out, start_out}, 32'h4);
		level <= 16'h0300;
		blk_req <= 1'b0;
		wait_out(3'b111, 3'b000);
		rd(REG_CNT_BLK, rv); chk(rv, 32'h1);
		chk({26'h0, ev_seen & 6'h30}, 32'h30);
		$display("test blocked pick-up done");
	endtask

	task automatic t_block_late;
		wr(REG_DELAY, 32'h000003E8);
		level <= 16'h0100;
		wait_out(3'b001, 3'b001);
		blk_req <= 1'b1;
		wait_out(3'b011, 3'b000);
		blk_req <= 1'b0;
		level <= 16'h0300;
		hold(12);
		$display("test blocking after start done");
	endtask

	task automatic t_noload;
		level <= 16'h0080;
		hold(30);
		chk({29'h0, blocked_out, trip_out, start_out}, 32'h0);
		level <= 16'h0300;
		hold(12);
		$display("test no-load lock done");
	endtask

	task automatic t_force_clear;
		int c;
		for (c = 0; c < 4; c++) begin
			wr(REG_CTRL, 32'h51 | (c << 1));
			hold(2);
			chk({29'h0, blocked_out, trip_out, start_out},
				(c == 0) ? 32'h0 : (32'h1 << (c - 1)));
		end
		wr(REG_CTRL, 32'h50);
		hold(2);
		wr(REG_CNT_CLR, 32'h7);
		rd(REG_CNT_START, rv); chk(rv, 32'h0);
		rd(REG_CNT_BLK, rv);   chk(rv, 32'h0);
		$display("test forcing and counter clear done");
	endtask

	// twelve forced trips push the oldest start record out of slot 0
	task automatic t_wrap;
		int k;
		for (k = 0; k < 12; k++) begin
			wr(REG_CTRL, 32'h55);
			wr(REG_CTRL, 32'h50);
		end
		hold(2);
		wr(REG_REC_SEL, 32'h0);
		rd(REG_REC_BASE + 8'h02, rv);
		chk({29'h0, rv[13:11]}, 32'(UCS_EV_TRIP_ON));
		$display("test record wrap done");
	endtask

	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// main sequence; group 5 marks every record
	initial begin
		hold(3);
		@(negedge clk_in);
		reset_n_in = 1'b1;
		hold(1);
		t_reset();
		wr(REG_CTRL, 32'h50);
		t_trip();
		t_blocked();
		t_block_late();
		t_noload();
		t_force_clear();
		t_wrap();
		tally_and_finish();
	end

	// watchdog sized well above the roughly 300 cycles used
	initial begin
		#(5000 * 50);
		n_mismatch++;
		tally_and_finish();
	end
endmodule
